// File: rtl/iwd_pkg.sv
// Purpose: Constants for the instruction word decode and timing block
// Assumes: 24-bit program words, 16-bit data, AHB-Lite register port
// Notes:   Field positions below are the decoder's own word layout
`default_nettype none
package iwd_pkg;
   // ----------------------------------------------------------------
   // Word geometry
   // ----------------------------------------------------------------
   localparam int OPC_HI   = 23;
   localparam int OPC_LO   = 16;
   localparam int FILE_TOP = 12;           // 13-bit file address
   // ----------------------------------------------------------------
   // Operand formats, supplied by the external opcode table
   // ----------------------------------------------------------------
   localparam logic [3:0] F_THREE  = 4'h0;
   localparam logic [3:0] F_FILE   = 4'h1;
   localparam logic [3:0] F_BITLIT = 4'h2;
   localparam logic [3:0] F_BITIND = 4'h3;
   localparam logic [3:0] F_LITU10 = 4'h4;
   localparam logic [3:0] F_LITS10 = 4'h5;
   localparam logic [3:0] F_MAC    = 4'h6;
   localparam logic [3:0] F_DSP    = 4'h7;
   localparam logic [3:0] F_SIGNED_FOUR_BIT_LITERAL  = 4'h8;
   localparam logic [3:0] F_CTRL   = 4'h9;
   // ----------------------------------------------------------------
   // Timing classes
   // ----------------------------------------------------------------
   localparam logic [2:0] T_PLAIN  = 3'h0;
   localparam logic [2:0] T_FLOW   = 3'h1;  // branch, table, return
   localparam logic [2:0] T_SKIP   = 3'h2;
   localparam logic [2:0] T_DWMOVE = 3'h3;
   // ----------------------------------------------------------------
   // Operation size codes (instruction word bits 1:0)
   // ----------------------------------------------------------------
   localparam logic [1:0] SZ_WORD  = 2'h0;
   localparam logic [1:0] SZ_BYTE  = 2'h1;
   localparam logic [1:0] SZ_DWORD = 2'h2;
   localparam logic [9:0] BYTE_LIT_MAX = 10'h0ff;
   // Accumulator write-back codes
   localparam logic [1:0] AWB_NONE = 2'h0;
   localparam logic [1:0] AWB_REG  = 2'h1;
   localparam logic [1:0] AWB_PINC = 2'h2;
   // ----------------------------------------------------------------
   // Register map (byte offsets) and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_STAT  = 8'h04;
   localparam logic [7:0] A_ERR   = 8'h08;
   localparam logic [7:0] A_ICNT  = 8'h0c;
   localparam logic [7:0] A_NCNT  = 8'h10;
   localparam logic [1:0] CTRL_RST = 2'h1;  // enabled, not strict
   // Error bits
   localparam int E_LIT   = 0;
   localparam int E_ODD   = 1;
   localparam int E_EXT   = 2;
   localparam int E_AWB   = 3;
   typedef enum logic [1:0] {S_FETCH, S_EXT, S_NOP} iwd_state_t;
endpackage : iwd_pkg
`default_nettype wire

// File: rtl/iwd_decode.sv
// Purpose: Fetch, decode and cycle timing for 24-bit instruction words
// Assumes: Opcode table outside gives format, timing class and flags
// Notes:   Inserted cycles drop PM_READY_O and raise NOP_O only
`default_nettype none
module iwd_decode
   import iwd_pkg::*;
(
   input  wire  logic        CLK_I,
   input  wire  logic        NRST_I,
   // AHB-Lite slave
   input  wire  logic        HSEL_I,
   input  wire  logic [31:0] HADDR_I,
   input  wire  logic [1:0]  HTRANS_I,
   input  wire  logic        HWRITE_I,
   input  wire  logic [2:0]  HSIZE_I,
   input  wire  logic [31:0] HWDATA_I,
   input  wire  logic        HREADY_I,
   output var   logic [31:0] HRDATA_O,
   output wire  logic        HREADYOUT_O,
   output wire  logic        HRESP_O,
   // Program memory word stream
   input  wire  logic        PM_VALID_I,
   input  wire  logic [23:0] PM_WORD_I,
   output wire  logic        PM_READY_O,
   // Opcode table and datapath answers for the offered word
   input  wire  logic [3:0]  FMT_I,
   input  wire  logic [2:0]  TIM_I,
   input  wire  logic        TWO_WORD_I,
   input  wire  logic [4:0]  CORE_FLAGS_I,
   input  wire  logic        COND_TRUE_I,
   input  wire  logic        PC_CHANGE_I,
   input  wire  logic        LONG_I,
   input  wire  logic        SKIP_TWO_I,
   input  wire  logic [15:0] BASE_DATA_I,
   // Decoded instruction
   output var   logic        EXEC_O,
   output var   logic        NOP_O,
   output var   logic [7:0]  OPCODE_O,
   output var   logic [1:0]  SIZE_O,
   output var   logic        SHADOW_O,
   output var   logic [3:0]  BASE_REG_O,
   output var   logic [3:0]  SRC_REG_O,
   output var   logic [1:0]  SRC_MODE_O,
   output var   logic [3:0]  DST_REG_O,
   output var   logic [1:0]  DST_MODE_O,
   output var   logic [12:0] FILE_ADDR_O,
   output var   logic        FILE_TO_WORKING_REG_ZERO_O,
   output var   logic [3:0]  BIT_POS_O,
   output var   logic [15:0] LIT_O,
   output var   logic [22:0] PROG_ADDR_O,
   output var   logic        ACC_SEL_O,
   output var   logic [2:0]  MUL_PAIR_O,
   output var   logic [3:0]  XPF_O,
   output var   logic [3:0]  YPF_O,
   output var   logic [1:0]  XD_O,
   output var   logic [1:0]  YD_O,
   output var   logic        AWB_EN_O,
   output var   logic        AWB_POSTINC_O,
   output var   logic        SHIFT_BY_REG_O,
   output var   logic [4:0]  CORE_FLAG_WE_O,
   output var   logic [3:0]  DSP_FLAG_WE_O
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   iwd_state_t  state;
   logic [1:0]  nop_cnt, ctrl, next_extra;
   logic [23:0] first_word, w, w2;
   logic [3:0]  hold_fmt, err, fmt, next_err;
   logic [4:0]  hold_flags, flags;
   logic [31:0] icnt, ncnt;
   logic [7:0]  last_opc, dp_addr;
   logic        take, orphan, go, ext_go, bad, ap_wr, ap_rd, dp_wr;
   assign take   = PM_VALID_I && PM_READY_O;
   assign orphan = take && (state == S_FETCH)
                   && (PM_WORD_I[OPC_HI:OPC_LO] == 8'h00);
   // Decode moment: single word, or second word of a pair
   assign go     = take && !orphan
                   && ((state == S_EXT) || !TWO_WORD_I);
   assign ext_go = go && (state == S_EXT);
   assign w      = ext_go ? first_word : PM_WORD_I;
   assign w2     = ext_go ? PM_WORD_I : 24'h000000;
   assign fmt    = ext_go ? hold_fmt : FMT_I;
   assign flags  = ext_go ? hold_flags : CORE_FLAGS_I;
   // Stalled during inserted cycles so nothing new is taken
   assign PM_READY_O = ctrl[0] && (state != S_NOP);

   // ----------------------------------------------------------------
   // Extra cycles and field checks
   // ----------------------------------------------------------------
   always_comb begin
      next_extra = 2'h0;
      case (TIM_I)
         T_PLAIN:  next_extra = (COND_TRUE_I || PC_CHANGE_I) ? 2'h1 : 2'h0;
         T_FLOW:   next_extra = LONG_I ? 2'h2 : 2'h1;
         // skip over one or two words
         T_SKIP:   next_extra = !COND_TRUE_I ? 2'h0 : (SKIP_TWO_I ? 2'h2 : 2'h1);
         T_DWMOVE: next_extra = 2'h1;
         default:  next_extra = 2'h0;
      endcase
      // the pair's two fetches already are its two cycles
      if (ext_go) next_extra = 2'h0;
   end

   always_comb begin
      next_err = 4'h0;
      next_err[E_LIT] = (fmt == F_LITU10) && (w[1:0] == SZ_BYTE)
                        && (w[13:4] > BYTE_LIT_MAX);
      next_err[E_ODD] = (fmt == F_CTRL) && w[0];
      next_err[E_EXT] = ext_go && (w2[OPC_HI:OPC_LO] != 8'h00);
      // only W13 or its post-increment form
      next_err[E_AWB] = (fmt == F_MAC) && (w[1:0] == 2'h3);
   end
   // Strict mode turns a malformed word into a no-op
   assign bad = ctrl[1] && (next_err != 4'h0);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         state   <= S_FETCH;
         nop_cnt <= 2'h0;
      end else begin
         case (state)
            S_FETCH: begin
               if (take && !orphan && TWO_WORD_I) begin
                  state <= S_EXT;
               end else if (go && next_extra != 2'h0) begin
                  state   <= S_NOP;
                  nop_cnt <= next_extra;
               end
            end
            S_EXT: begin
               if (take) begin
                  state <= S_FETCH;
               end
            end
            S_NOP: begin
               nop_cnt <= nop_cnt - 2'h1;
               if (nop_cnt == 2'h1) begin
                  state <= S_FETCH;
               end
            end
            default: state <= S_FETCH;
         endcase
      end
   end

   // First word of a pair and its table answers wait for the second
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         first_word <= 24'h000000;
         hold_fmt   <= 4'h0;
         hold_flags <= 5'h00;
      end else if (take && state == S_FETCH && TWO_WORD_I) begin
         first_word <= PM_WORD_I;
         hold_fmt   <= FMT_I;
         hold_flags <= CORE_FLAGS_I;
      end
   end

   // ----------------------------------------------------------------
   // Execute strobes and flag write enables
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         EXEC_O         <= 1'b0;
         NOP_O          <= 1'b0;
         CORE_FLAG_WE_O <= 5'h00;
         DSP_FLAG_WE_O  <= 4'h0;
      end else begin
         EXEC_O <= go && !bad;
         NOP_O  <= orphan || (go && bad) || (state == S_NOP);
         CORE_FLAG_WE_O <= 5'h00;
         DSP_FLAG_WE_O  <= 4'h0;
         if (go && !bad) begin
            // accumulator formats leave core flags alone
            if (fmt == F_MAC || fmt == F_DSP || fmt == F_SIGNED_FOUR_BIT_LITERAL) begin
               DSP_FLAG_WE_O <= 4'hf;
            end else begin
               CORE_FLAG_WE_O <= flags;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Operand fields, held until the next decode
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         OPCODE_O       <= 8'h00;
         SIZE_O         <= SZ_WORD;
         SHADOW_O       <= 1'b0;
         BASE_REG_O     <= 4'h0;
         SRC_REG_O      <= 4'h0;
         SRC_MODE_O     <= 2'h0;
         DST_REG_O      <= 4'h0;
         DST_MODE_O     <= 2'h0;
         FILE_ADDR_O    <= 13'h0000;
         FILE_TO_WORKING_REG_ZERO_O <= 1'b0;
         BIT_POS_O      <= 4'h0;
         LIT_O          <= 16'h0000;
         PROG_ADDR_O    <= 23'h000000;
         ACC_SEL_O      <= 1'b0;
         MUL_PAIR_O     <= 3'h0;
         XPF_O          <= 4'h0;
         YPF_O          <= 4'h0;
         XD_O           <= 2'h0;
         YD_O           <= 2'h0;
         AWB_EN_O       <= 1'b0;
         AWB_POSTINC_O  <= 1'b0;
         SHIFT_BY_REG_O <= 1'b0;
      end else if (go) begin
         OPCODE_O       <= w[OPC_HI:OPC_LO];
         SIZE_O         <= (w[1:0] == 2'h3) ? SZ_WORD : w[1:0];
         SHADOW_O       <= w[2];
         BASE_REG_O     <= w[15:12];
         DST_MODE_O     <= w[11:10];
         DST_REG_O      <= w[9:6];
         SRC_MODE_O     <= w[5:4];
         SRC_REG_O      <= w[3:0];
         FILE_ADDR_O    <= w[FILE_TOP:0];
         FILE_TO_WORKING_REG_ZERO_O <= w[13];
         BIT_POS_O      <= (fmt == F_BITIND) ? BASE_DATA_I[3:0]
                                             : w[15:12];
         case (fmt)
            F_LITU10: LIT_O <= {6'h00, w[13:4]};
            F_LITS10: LIT_O <= {{6{w[13]}}, w[13:4]};
            F_SIGNED_FOUR_BIT_LITERAL:  LIT_O <= {{12{w[14]}}, w[14:11]};
            F_DSP:    LIT_O <= {{10{w[5]}}, w[5:0]};
            default:  LIT_O <= w[15:0];
         endcase
         PROG_ADDR_O    <= {w2[6:0], w[15:1], 1'b0};
         ACC_SEL_O      <= w[15];
         MUL_PAIR_O     <= w[14:12];
         XPF_O          <= w[11:8];
         YPF_O          <= w[7:4];
         XD_O           <= w[3:2];
         YD_O           <= w[1:0];
         AWB_EN_O       <= (fmt == F_MAC)
                           && (w[1:0] == AWB_REG || w[1:0] == AWB_PINC);
         AWB_POSTINC_O  <= (fmt == F_MAC) && (w[1:0] == AWB_PINC);
         SHIFT_BY_REG_O <= (fmt == F_DSP) && w[8];
      end
   end

   // ----------------------------------------------------------------
   // Counters and sticky errors
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         icnt     <= 32'h00000000;
         ncnt     <= 32'h00000000;
         last_opc <= 8'h00;
      end else begin
         if (go && !bad) begin
            icnt     <= icnt + 32'h00000001;
            last_opc <= w[OPC_HI:OPC_LO];
         end
         if (orphan || (go && bad) || state == S_NOP) begin
            ncnt <= ncnt + 32'h00000001;
         end
      end
   end

   // New errors win over a write-one-to-clear in the same cycle
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         err <= 4'h0;
      end else begin
         err <= (err & ~((dp_wr && dp_addr == A_ERR) ? HWDATA_I[3:0]
                                                      : 4'h0))
                | (go ? next_err : 4'h0);
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave: zero wait, always OKAY
   // ----------------------------------------------------------------
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O     = 1'b0;
   assign ap_wr = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
   assign ap_rd = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;

   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         dp_wr   <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_wr   <= ap_wr;
         dp_addr <= HADDR_I[7:0];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         ctrl <= CTRL_RST;
      end else if (dp_wr && dp_addr == A_CTRL) begin
         ctrl <= HWDATA_I[1:0];
      end
   end

   // Read data is fetched in the address phase to stand from a flop
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         HRDATA_O <= 32'h00000000;
      end else if (ap_rd) begin
         case (HADDR_I[7:0])
            A_CTRL:  HRDATA_O <= {30'h00000000, ctrl};
            A_STAT:  HRDATA_O <= {20'h00000, last_opc, nop_cnt, state};
            A_ERR:   HRDATA_O <= {28'h0000000, err};
            A_ICNT:  HRDATA_O <= icnt;
            A_NCNT:  HRDATA_O <= ncnt;
            default: HRDATA_O <= 32'h00000000;
         endcase
      end
   end
endmodule : iwd_decode
`default_nettype wire

// File: testbench/iwd_decode_props.sv
// Purpose: Port checker for the decode and timing block
// Assumes: One clock, synchronous active-low reset
// Notes:   Pair state is rebuilt here from the word handshake
`default_nettype none
module iwd_decode_props
   import iwd_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        NRST_I,
   input  wire logic        PM_VALID_I,
   input  wire logic [23:0] PM_WORD_I,
   input  wire logic        PM_READY_O,
   input  wire logic [3:0]  FMT_I,
   input  wire logic [2:0]  TIM_I,
   input  wire logic        TWO_WORD_I,
   input  wire logic        COND_TRUE_I,
   input  wire logic        PC_CHANGE_I,
   input  wire logic        LONG_I,
   input  wire logic        SKIP_TWO_I,
   input  wire logic [15:0] BASE_DATA_I,
   input  wire logic        EXEC_O,
   input  wire logic        NOP_O,
   input  wire logic [7:0]  OPCODE_O,
   input  wire logic [3:0]  BIT_POS_O,
   input  wire logic [4:0]  CORE_FLAG_WE_O,
   input  wire logic [3:0]  DSP_FLAG_WE_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   // ----------------------------------------------------------
   // Pair tracking
   // ----------------------------------------------------------
   logic in_ext;
   logic take;
   logic first;
   logic one;
   assign take  = PM_VALID_I && PM_READY_O;
   assign first = take && !in_ext && (PM_WORD_I[23:16] != 8'h00);
   assign one   = first && !TWO_WORD_I;
   // Any word taken after a pair opener is its second half
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         in_ext <= 1'b0;
      end else if (take) begin
         in_ext <= first && TWO_WORD_I;
      end
   end
   sequence s_exec; EXEC_O && !PM_READY_O; endsequence
   sequence s_ins;  !PM_READY_O && NOP_O; endsequence
   sequence s_back; PM_READY_O && NOP_O; endsequence
   // ----------------------------------------------------------
   // Properties
   // ----------------------------------------------------------
   a_take_answered: assert property (
      take && !(first && TWO_WORD_I) |=> EXEC_O || NOP_O)
      else $error("taken word gave neither exec nor no-op");
   a_lone_nop: assert property (
      take && !in_ext && PM_WORD_I[23:16] == 8'h00
      |=> NOP_O && !EXEC_O && $stable(OPCODE_O))
      else $error("lone second word did not act as no-op");
   a_cond_extra: assert property (
      one && TIM_I == T_PLAIN && (COND_TRUE_I || PC_CHANGE_I)
      |=> s_exec ##1 s_back)
      else $error("conditional word lacks its added cycle");
   a_flow_long: assert property (
      one && TIM_I == T_FLOW && LONG_I |=> s_exec ##1 s_ins ##1 s_back)
      else $error("long flow word not three cycles");
   a_skip_two: assert property (
      one && TIM_I == T_SKIP && COND_TRUE_I && SKIP_TWO_I
      |=> s_exec ##1 s_ins ##1 s_back)
      else $error("skip over pair not three cycles");
   a_pair_open: assert property (
      first && TWO_WORD_I |=> PM_READY_O && !EXEC_O && !NOP_O)
      else $error("pair opener stalled or executed alone");
   a_signed_four_bit_literal_core: assert property (
      one && FMT_I == F_SIGNED_FOUR_BIT_LITERAL |=> CORE_FLAG_WE_O == 5'h00)
      else $error("short literal add touched core flags");
   a_nop_quiet: assert property (
      NOP_O |-> CORE_FLAG_WE_O == 5'h00 && DSP_FLAG_WE_O == 4'h0)
      else $error("flag write during a no-op cycle");
   a_bit_indirect: assert property (
      one && FMT_I == F_BITIND |=> BIT_POS_O == $past(BASE_DATA_I[3:0]))
      else $error("indirect bit position not from base data");
endmodule : iwd_decode_props
bind iwd_decode iwd_decode_props u_props (
   .CLK_I(CLK_I), .NRST_I(NRST_I), .PM_VALID_I(PM_VALID_I),
   .PM_WORD_I(PM_WORD_I), .PM_READY_O(PM_READY_O), .FMT_I(FMT_I),
   .TIM_I(TIM_I), .TWO_WORD_I(TWO_WORD_I), .COND_TRUE_I(COND_TRUE_I),
   .PC_CHANGE_I(PC_CHANGE_I), .LONG_I(LONG_I), .SKIP_TWO_I(SKIP_TWO_I),
   .BASE_DATA_I(BASE_DATA_I), .EXEC_O(EXEC_O), .NOP_O(NOP_O),
   .OPCODE_O(OPCODE_O), .BIT_POS_O(BIT_POS_O),
   .CORE_FLAG_WE_O(CORE_FLAG_WE_O), .DSP_FLAG_WE_O(DSP_FLAG_WE_O));
`default_nettype wire

// File: testbench/iwd_pm_model.sv
// Purpose: Program memory model offering instruction words
// Assumes: Word held until the decoder takes it at a rising edge
// Notes:   Released word lines show the inverse so stale data cannot pass
`default_nettype none
module iwd_pm_model (
   input  wire logic        CLK_I,
   input  wire logic        READY_I,
   output var  logic        VALID_O,
   output var  logic [23:0] WORD_O
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      VALID_O = 1'b0;
      WORD_O  = 24'h5a5a5a;
   end
   // whole words
   // Slow answers wait extra edges before offering
   task automatic offer(input logic [23:0] w, input int slow);
      repeat (slow + 1) @(posedge CLK_I);
      VALID_O <= 1'b1;
      WORD_O  <= w;
      do @(negedge CLK_I); while (READY_I !== 1'b1);
      @(posedge CLK_I);
      VALID_O <= 1'b0;
      WORD_O  <= ~w;
   endtask : offer
endmodule : iwd_pm_model
`default_nettype wire

// File: testbench/instruction_word_decode_timing_tb_top.sv
// Purpose: Self-checking bench for the decode and timing block
// Assumes: Zero-wait register port, word source model on fetch side
// Notes:   Opcode table answers are driven here for each word
`default_nettype none
module instruction_word_decode_timing_tb_top
   import iwd_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------
   // Signals
   // ----------------------------------------------------------
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0]  fmt = 4'h0;
   logic [2:0]  tim = 3'h0;
   logic        two = 1'b0;
   logic        cond = 1'b0;
   logic        pcc = 1'b0;
   logic        lng = 1'b0;
   logic        sk2 = 1'b0;
   logic [4:0]  cflg = 5'h0;
   logic [15:0] bdat = 16'h0;
   logic [8:0]  we_seen;
   logic [31:0] rd;
   wire         hready, pm_valid, pm_ready, exec, nop, shadow;
   wire         to_working_reg_zero, acc, awb_en, awb_pi;
   wire  [31:0] hrdata;
   wire  [23:0] pm_word;
   wire  [7:0]  opc;
   wire  [1:0]  size, dmode, smode;
   wire  [3:0]  base, src, dst, bitp, xpf, dspwe;
   wire  [12:0] faddr;
   wire  [15:0] lit;
   wire  [22:0] paddr;
   wire  [4:0]  corewe;
   int          err_total = 0;
   int          checks = 0;
   int          cyc = 0;
   // Clock, 10 ns period
   always #5 clk = ~clk;
   iwd_pm_model u_pm (.CLK_I(clk), .READY_I(pm_ready),
      .VALID_O(pm_valid), .WORD_O(pm_word));
   iwd_decode u_dut (
      .CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
      .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(), .PM_VALID_I(pm_valid),
      .PM_WORD_I(pm_word), .PM_READY_O(pm_ready), .FMT_I(fmt),
      .TIM_I(tim), .TWO_WORD_I(two), .CORE_FLAGS_I(cflg),
      .COND_TRUE_I(cond), .PC_CHANGE_I(pcc), .LONG_I(lng),
      .SKIP_TWO_I(sk2), .BASE_DATA_I(bdat), .EXEC_O(exec), .NOP_O(nop),
      .OPCODE_O(opc), .SIZE_O(size), .SHADOW_O(shadow),
      .BASE_REG_O(base), .SRC_REG_O(src), .SRC_MODE_O(smode),
      .DST_REG_O(dst), .DST_MODE_O(dmode), .FILE_ADDR_O(faddr),
      .FILE_TO_WORKING_REG_ZERO_O(to_working_reg_zero), .BIT_POS_O(bitp), .LIT_O(lit),
      .PROG_ADDR_O(paddr), .ACC_SEL_O(acc), .MUL_PAIR_O(), .XPF_O(xpf),
      .YPF_O(), .XD_O(), .YD_O(), .AWB_EN_O(awb_en),
      .AWB_POSTINC_O(awb_pi), .SHIFT_BY_REG_O(), .CORE_FLAG_WE_O(corewe),
      .DSP_FLAG_WE_O(dspwe));
   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Single word transfer; read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      d = hrdata;
      hsel <= 1'b0;
   endtask : ahb
   // Table answers lead the offered word
   task automatic put(input logic [23:0] w, input logic [3:0] f,
      input logic [2:0] t, input logic [3:0] c, input logic tw,
      input int slow);
      @(posedge clk);
      fmt  <= f;
      tim  <= t;
      two  <= tw;
      cflg <= w[4:0];
      bdat <= ~w[15:0];
      {cond, pcc, lng, sk2} <= c;
      u_pm.offer(w, slow);
   endtask : put
   // Stalled and no-op cycles after the take
   task automatic watch(input logic ex, input int nlo, input int nno);
      int lo;
      int nc;
      lo = 0;
      nc = 0;
      @(negedge clk);
      chk("exec", ex, exec);
      we_seen = {dspwe, corewe};
      repeat (4) begin
         lo += (pm_ready !== 1'b1);
         nc += (nop === 1'b1);
         @(negedge clk);
      end
      chk("ready low cycles", nlo, lo);
      chk("no-op cycles", nno, nc);
   endtask : watch
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         conclude();
      end
   end
   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      int          i;
      logic [23:0] w;
      logic [8:0]  tab [9];
      tab = '{{T_PLAIN, 4'h0, 2'h0}, {T_PLAIN, 4'h8, 2'h1},
              {T_PLAIN, 4'h4, 2'h1}, {T_FLOW, 4'h2, 2'h2},
              {T_FLOW, 4'h0, 2'h1}, {T_SKIP, 4'h9, 2'h2},
              {T_SKIP, 4'h8, 2'h1}, {T_SKIP, 4'h1, 2'h0},
              {T_DWMOVE, 4'h0, 2'h1}};
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      // Reset values; the count register ignores writes
      ahb(1'b1, A_ICNT, 32'h5, rd);
      for (i = 0; i < 6; i++) begin
         ahb(1'b0, 32'(i * 4), 32'h0, rd);
         chk("reset value", (i == 0) ? 32'h1 : 32'h0, rd);
      end
      ahb(1'b1, A_CTRL, 32'h0, rd);
      @(negedge clk);
      chk("ready disabled", 1'b0, pm_ready);
      ahb(1'b1, A_CTRL, 32'h1, rd);
      // Every timing class, with slow and prompt word delivery
      for (i = 0; i < 9; i++) begin
         w = {8'h12 + 8'(i), 16'hb6e7 ^ 16'(i)};
         put(w, F_THREE, tab[i][8:6], tab[i][5:2], 1'b0, i % 3);
         watch(1'b1, int'(tab[i][1:0]), int'(tab[i][1:0]));
         chk("opcode", w[23:16], opc);
         chk("base", w[15:12], base);
         chk("source", w[5:0], {smode, src});
         chk("dest", w[11:6], {dmode, dst});
         chk("size", (w[1:0] == 2'h3) ? SZ_WORD : w[1:0], size);
         chk("shadow", w[2], shadow);
         chk("core flag we", {4'h0, w[4:0]}, we_seen);
      end
      put(24'h313fff, F_FILE, T_PLAIN, 4'h0, 1'b0, 0);
      watch(1'b1, 0, 0);
      chk("file addr", 13'h1fff, faddr);
      chk("to working_reg_zero", 1'b1, to_working_reg_zero);
      put(24'h32a000, F_BITLIT, T_PLAIN, 4'h0, 1'b0, 0);
      watch(1'b1, 0, 0);
      chk("bit literal", 4'ha, bitp);
      put(24'h330005, F_BITIND, T_PLAIN, 4'h0, 1'b0, 1);
      watch(1'b1, 0, 0);
      chk("bit indirect", 4'ha, bitp);
      put(24'h403ff0, F_LITU10, T_PLAIN, 4'h0, 1'b0, 0);
      watch(1'b1, 0, 0);
      chk("unsigned lit", 16'h03ff, lit);
      put(24'h412000, F_LITS10, T_PLAIN, 4'h0, 1'b0, 0);
      watch(1'b1, 0, 0);
      chk("signed lit", 16'hfe00, lit);
      put(24'h70401f, F_SIGNED_FOUR_BIT_LITERAL, T_PLAIN, 4'h0, 1'b0, 0);
      watch(1'b1, 0, 0);
      chk("short lit", 16'hfff8, lit);
      chk("short lit core we", 9'h1e0, we_seen);
      // Accumulator write-back codes, the last one illegal
      for (i = 1; i < 4; i++) begin
         put({8'h60, 14'h27d5, 2'(i)}, F_MAC, T_PLAIN, 4'h0, 1'b0, 0);
         watch(1'b1, 0, 0);
         chk("acc select", 1'b1, acc);
         chk("x prefetch", 4'hf, xpf);
         chk("write-back", {i != 3, i == 2}, {awb_en, awb_pi});
         ahb(1'b0, A_ERR, 32'h0, rd);
         chk("awb error", (i == 3) ? 32'h8 : 32'h0, rd);
      end
      ahb(1'b1, A_ERR, 32'hf, rd);
      // Byte literal above range, then again in strict mode
      put(24'h421001, F_LITU10, T_PLAIN, 4'h0, 1'b0, 0);
      watch(1'b1, 0, 0);
      ahb(1'b0, A_ERR, 32'h0, rd);
      chk("lit error", 32'h1, rd);
      ahb(1'b1, A_CTRL, 32'h3, rd);
      put(24'h421001, F_LITU10, T_PLAIN, 4'h0, 1'b0, 0);
      watch(1'b0, 0, 1);
      ahb(1'b1, A_CTRL, 32'h1, rd);
      ahb(1'b1, A_ERR, 32'hf, rd);
      ahb(1'b0, A_ERR, 32'h0, rd);
      chk("error cleared", 32'h0, rd);
      // Good pair, then a pair with odd address and bad top byte
      put(24'h501234, F_CTRL, T_PLAIN, 4'h0, 1'b1, 0);
      put(24'h000045, F_CTRL, T_PLAIN, 4'h0, 1'b0, 1);
      watch(1'b1, 0, 0);
      chk("prog addr", {7'h45, 15'h091a, 1'b0}, paddr);
      put(24'h501235, F_CTRL, T_PLAIN, 4'h0, 1'b1, 0);
      put(24'h070001, F_CTRL, T_PLAIN, 4'h0, 1'b0, 0);
      watch(1'b1, 0, 0);
      chk("odd prog addr", {7'h01, 15'h091a, 1'b0}, paddr);
      ahb(1'b0, A_ERR, 32'h0, rd);
      chk("pair errors", 32'h6, rd);
      ahb(1'b1, A_ERR, 32'hf, rd);
      // Second word fetched alone
      put(24'h000abc, F_THREE, T_PLAIN, 4'h0, 1'b0, 0);
      watch(1'b0, 0, 1);
      chk("opcode held", 8'h50, opc);
      chk("no-op flag we", 9'h000, we_seen);
      conclude();
   end
endmodule : instruction_word_decode_timing_tb_top
`default_nettype wire
